// *** core/odc_consts.svh ***
// Constants for the operating definition change command block
`ifndef ODC_CONSTS_SVH
`define ODC_CONSTS_SVH

// ****************************************************************
// Opcodes of the commands common to all device types
// ****************************************************************
`define ODC_OP_CHG_DEF      8'h40
`define ODC_OP_COMPARE      8'h39
`define ODC_OP_COPY         8'h18
`define ODC_OP_COPY_VERIFY  8'h3A
`define ODC_OP_INQUIRY      8'h12
`define ODC_OP_LOG_SELECT   8'h4C
`define ODC_OP_LOG_SENSE    8'h4D
`define ODC_OP_MODE_SEL6    8'h15
`define ODC_OP_MODE_SEL10   8'h55
`define ODC_OP_MODE_SNS6    8'h1A
`define ODC_OP_MODE_SNS10   8'h5A
`define ODC_OP_READ_BUF     8'h3C
`define ODC_OP_RCV_DIAG     8'h1C
`define ODC_OP_REQ_SENSE    8'h03
`define ODC_OP_SEND_DIAG    8'h1D
`define ODC_OP_TEST_READY   8'h00
`define ODC_OP_WRITE_BUF    8'h3B

// ****************************************************************
// Descriptor layout
// ****************************************************************
`define ODC_CDB_LEN         4'hA
`define ODC_BYTE_OPC        4'h0
`define ODC_BYTE_LUN        4'h1
`define ODC_BYTE_SAVE       4'h2
`define ODC_BYTE_DEFP       4'h3
`define ODC_BYTE_PLEN       4'h8
`define ODC_BYTE_CTRL       4'h9
`define ODC_LUN_MSB         7
`define ODC_LUN_LSB         5
`define ODC_SAVE_BIT        0
`define ODC_DEFP_MSB        6

// ****************************************************************
// Definition parameter values and levels
// ****************************************************************
`define ODC_DEFP_KEEP       7'h00
`define ODC_DEFP_LVL1       7'h01
`define ODC_DEFP_LVL2       7'h02
`define ODC_DEFP_LVL3       7'h03
`define ODC_DEFP_VEND_LO    7'h40
`define ODC_LVL_LEGACY1     2'h1
`define ODC_LVL_LEGACY2     2'h2
`define ODC_LVL_CURRENT     2'h3
`define ODC_LVL_RESET       2'h3

// ****************************************************************
// Status, inquiry and sense values
// ****************************************************************
`define ODC_STAT_GOOD       8'h00
`define ODC_STAT_CHECK      8'h02
`define ODC_VER_LVL1        8'h01
`define ODC_VER_LVL2        8'h01
`define ODC_VER_LVL3        8'h02
`define ODC_FMT_LVL1        4'h0
`define ODC_FMT_LVL2        4'h1
`define ODC_FMT_LVL3        4'h2
`define ODC_FEAT_ALL        8'hFF
`define ODC_SENSE0_LEGACY   8'h04
`define ODC_SENSE0_CURRENT  8'h00

`endif

// *** core/odc_pkg.sv ***
// Types shared by the operating definition change block
package odc_pkg;

  typedef enum logic [4:0] {
    ODC_CL_CHG_DEF, ODC_CL_COMPARE, ODC_CL_COPY, ODC_CL_COPY_VERIFY,
    ODC_CL_INQUIRY, ODC_CL_LOG_SELECT, ODC_CL_LOG_SENSE,
    ODC_CL_MODE_SELECT, ODC_CL_MODE_SENSE, ODC_CL_READ_BUF,
    ODC_CL_RCV_DIAG, ODC_CL_REQ_SENSE, ODC_CL_SEND_DIAG,
    ODC_CL_TEST_READY, ODC_CL_WRITE_BUF, ODC_CL_UNKNOWN
  } odc_class_t;

  typedef enum logic [3:0] {
    ODC_ST_LOAD, ODC_ST_LOAD_WAIT, ODC_ST_IDLE, ODC_ST_EVAL,
    ODC_ST_DATA, ODC_ST_STATUS, ODC_ST_ACK, ODC_ST_SAVE_WAIT
  } odc_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] lun;
    logic       save;
    logic [6:0] defp;
    logic [7:0] plen;
  } odc_cdb_t;

  typedef struct packed {
    logic [7:0] version;
    logic [3:0] format;
    logic [7:0] feat_mask;
    logic [7:0] sense_len0;
    logic       aen_ok;
    logic       recovery_ok;
    logic       legacy;
  } odc_query_t;

endpackage : odc_pkg

// *** core/odc_opdec.sv ***
// Opcode decoder for the commands common to all device types
`timescale 1ns/1ps
`include "odc_consts.svh"

module odc_opdec
  import odc_pkg::*;
(
  input  wire logic [7:0] opcode_i,
  output odc_class_t      class_o,
  output logic            mandatory_o
);

  always_comb begin
    mandatory_o = 1'b0;
    case (opcode_i)
      `ODC_OP_CHG_DEF:     class_o = ODC_CL_CHG_DEF;
      `ODC_OP_COMPARE:     class_o = ODC_CL_COMPARE;
      `ODC_OP_COPY:        class_o = ODC_CL_COPY;
      `ODC_OP_COPY_VERIFY: class_o = ODC_CL_COPY_VERIFY;
      `ODC_OP_INQUIRY: begin
        class_o     = ODC_CL_INQUIRY;
        mandatory_o = 1'b1;
      end
      `ODC_OP_LOG_SELECT:  class_o = ODC_CL_LOG_SELECT;
      `ODC_OP_LOG_SENSE:   class_o = ODC_CL_LOG_SENSE;
      `ODC_OP_MODE_SEL6,
      `ODC_OP_MODE_SEL10:  class_o = ODC_CL_MODE_SELECT;
      `ODC_OP_MODE_SNS6,
      `ODC_OP_MODE_SNS10:  class_o = ODC_CL_MODE_SENSE;
      `ODC_OP_READ_BUF:    class_o = ODC_CL_READ_BUF;
      `ODC_OP_RCV_DIAG:    class_o = ODC_CL_RCV_DIAG;
      `ODC_OP_REQ_SENSE: begin
        class_o     = ODC_CL_REQ_SENSE;
        mandatory_o = 1'b1;
      end
      `ODC_OP_SEND_DIAG: begin
        class_o     = ODC_CL_SEND_DIAG;
        mandatory_o = 1'b1;
      end
      `ODC_OP_TEST_READY: begin
        class_o     = ODC_CL_TEST_READY;
        mandatory_o = 1'b1;
      end
      `ODC_OP_WRITE_BUF:   class_o = ODC_CL_WRITE_BUF;
      default:             class_o = ODC_CL_UNKNOWN;
    endcase
  end

endmodule : odc_opdec

// *** core/odc_core.sv ***
// Target-side common command decoder and definition change engine
`timescale 1ns/1ps
`include "odc_consts.svh"

module odc_core
  import odc_pkg::*;
#(
  parameter int          NUM_LUN  = 8,
  parameter int          NUM_INIT = 8,
  parameter bit          SAVE_EN  = 1'b1,
  parameter logic [15:0] PASS_KEY = 16'h5A5A  // Arbitrary value
) (
  input  wire logic                    mclk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    cdb_valid_i,
  input  wire logic [7:0]              cdb_byte_i,
  input  wire logic                    dout_valid_i,
  input  wire logic [7:0]              dout_byte_i,
  input  wire logic                    abort_i,
  input  wire logic                    msg_ack_i,
  input  wire logic [NUM_LUN*2-1:0]    nv_rdata_i,
  input  wire logic                    nv_done_i,
  input  wire logic                    nv_err_i,
  input  wire logic                    ua_clr_i,
  input  wire logic [2:0]              ua_clr_lun_i,
  input  wire logic [2:0]              ua_clr_init_i,
  input  wire logic [2:0]              qry_lun_i,
  output logic                         dout_req_o,
  output logic                         status_valid_o,
  output logic [7:0]                   status_o,
  output logic                         cmd_other_o,
  output odc_class_t                   cmd_class_o,
  output logic                         cmd_mandatory_o,
  output logic                         nv_rd_o,
  output logic                         nv_wr_o,
  output logic [NUM_LUN*2-1:0]         nv_wdata_o,
  output logic [NUM_LUN*NUM_INIT-1:0]  ua_o,
  output logic [NUM_LUN*2-1:0]         def_o,
  output odc_query_t                   qry_o,
  output logic                         busy_o
);

  if (NUM_LUN < 1 || NUM_LUN > 8 || NUM_INIT < 1 || NUM_INIT > 8) begin
    $error("odc_core: NUM_LUN and NUM_INIT must lie in 1..8");
  end

  // ****************************************************************
  // Opcode classification
  // ****************************************************************
  odc_cdb_t   cdb;
  odc_class_t dec_class;
  logic       dec_mand;

  odc_opdec u_opdec (
    .opcode_i    (cdb.opcode),
    .class_o     (dec_class),
    .mandatory_o (dec_mand)
  );

  // ****************************************************************
  // Command engine state
  // ****************************************************************
  odc_state_t                  state;
  odc_state_t                  next_state;
  odc_cdb_t                    next_cdb;
  logic [3:0]                  byte_cnt;
  logic [3:0]                  next_byte_cnt;
  logic [7:0]                  data_cnt;
  logic [7:0]                  next_data_cnt;
  logic                        fail;
  logic                        next_fail;
  logic                        pw_ok;
  logic                        next_pw_ok;
  logic [NUM_LUN*2-1:0]        next_def;
  logic [NUM_LUN*2-1:0]        prior_def;
  logic [NUM_LUN*2-1:0]        next_prior_def;
  logic [NUM_LUN-1:0]          ua_lun_set;
  logic                        next_dout_req;
  logic                        next_status_valid;
  logic [7:0]                  next_status;
  logic                        next_cmd_other;
  odc_class_t                  next_cmd_class;
  logic                        next_cmd_mand;
  logic                        next_nv_rd;
  logic                        next_nv_wr;
  logic [NUM_LUN*2-1:0]        next_nv_wdata;
  logic                        take_data;

  assign take_data = dout_req_o && dout_valid_i;

  always_comb begin
    next_state        = state;
    next_cdb          = cdb;
    next_byte_cnt     = byte_cnt;
    next_data_cnt     = data_cnt;
    next_fail         = fail;
    next_pw_ok        = pw_ok;
    next_def          = def_o;
    next_prior_def    = prior_def;
    ua_lun_set        = '0;
    next_dout_req     = 1'b0;
    next_status_valid = 1'b0;
    next_status       = status_o;
    next_cmd_other    = 1'b0;
    next_cmd_class    = cmd_class_o;
    next_cmd_mand     = cmd_mandatory_o;
    next_nv_rd        = 1'b0;
    next_nv_wr        = 1'b0;
    next_nv_wdata     = nv_wdata_o;
    case (state)
      ODC_ST_LOAD: begin
        if (SAVE_EN) begin
          next_nv_rd = 1'b1;
          next_state = ODC_ST_LOAD_WAIT;
        end else begin
          next_state = ODC_ST_IDLE;
        end
      end
      ODC_ST_LOAD_WAIT: begin
        if (nv_done_i) begin
          // A failed read leaves the default definition in place
          if (!nv_err_i) begin
            next_def = nv_rdata_i;
          end
          next_state = ODC_ST_IDLE;
        end
      end
      ODC_ST_IDLE: begin
        if (cdb_valid_i) begin
          case (byte_cnt)
            `ODC_BYTE_OPC:  next_cdb.opcode = cdb_byte_i;
            `ODC_BYTE_LUN:
              next_cdb.lun = cdb_byte_i[`ODC_LUN_MSB:`ODC_LUN_LSB];
            `ODC_BYTE_SAVE: next_cdb.save = cdb_byte_i[`ODC_SAVE_BIT];
            `ODC_BYTE_DEFP: next_cdb.defp = cdb_byte_i[`ODC_DEFP_MSB:0];
            `ODC_BYTE_PLEN: next_cdb.plen = cdb_byte_i;
            default:        next_cdb = cdb;
          endcase
          next_byte_cnt = byte_cnt + 4'h1;
          if (byte_cnt == `ODC_CDB_LEN - 4'h1) begin
            next_byte_cnt = 4'h0;
            next_state    = ODC_ST_EVAL;
          end
        end
      end
      ODC_ST_EVAL: begin
        next_cmd_class = dec_class;
        next_cmd_mand  = dec_mand;
        next_data_cnt  = 8'h00;
        next_pw_ok     = 1'b0;
        next_fail      = 1'b0;
        if (dec_class != ODC_CL_CHG_DEF) begin
          next_cmd_other = 1'b1;
          next_state     = ODC_ST_IDLE;
        end else begin
          // Accepted whatever level the unit runs at
          next_prior_def = def_o;
          if (32'(cdb.lun) >= NUM_LUN) begin
            next_fail = 1'b1;
          end
          if (cdb.defp > `ODC_DEFP_LVL3) begin
            next_fail = 1'b1;
          end
          if (cdb.plen == 8'h00) begin
            next_pw_ok = 1'b1;
            next_state = ODC_ST_STATUS;
          end else begin
            next_dout_req = 1'b1;
            next_state    = ODC_ST_DATA;
          end
        end
      end
      ODC_ST_DATA: begin
        next_dout_req = 1'b1;
        if (take_data) begin
          next_data_cnt = data_cnt + 8'h01;
          // Password must be the first two parameter bytes
          if (data_cnt == 8'h00) begin
            // A single byte can never carry the whole password
            next_pw_ok = (dout_byte_i == PASS_KEY[15:8])
                         && (cdb.plen != 8'h01);
          end else if (data_cnt == 8'h01) begin
            next_pw_ok = pw_ok && (dout_byte_i == PASS_KEY[7:0]);
          end
          if (next_data_cnt == cdb.plen) begin
            next_dout_req = 1'b0;
            next_state    = ODC_ST_STATUS;
          end
        end
        if (abort_i) begin
          next_dout_req = 1'b0;
          next_state    = ODC_ST_IDLE;
        end
      end
      ODC_ST_STATUS: begin
        next_status_valid = 1'b1;
        if (fail || !pw_ok) begin
          next_status = `ODC_STAT_CHECK;
          next_state  = ODC_ST_IDLE;
        end else begin
          next_status = `ODC_STAT_GOOD;
          next_state  = ODC_ST_ACK;
        end
        if (abort_i) begin
          next_status_valid = 1'b0;
          next_state        = ODC_ST_IDLE;
        end
      end
      ODC_ST_ACK: begin
        if (abort_i) begin
          next_def   = prior_def;
          next_state = ODC_ST_IDLE;
        end else if (msg_ack_i) begin
          // Nothing changes before the completion acknowledge
          if (cdb.defp != `ODC_DEFP_KEEP) begin
            next_def[32'(cdb.lun)*2 +: 2] = cdb.defp[1:0];
            if (def_o[32'(cdb.lun)*2 +: 2] != cdb.defp[1:0]) begin
              ua_lun_set[32'(cdb.lun)] = 1'b1;
            end
          end
          if (cdb.save && SAVE_EN) begin
            next_nv_wr    = 1'b1;
            next_nv_wdata = next_def;
            next_state    = ODC_ST_SAVE_WAIT;
          end else begin
            next_state = ODC_ST_IDLE;
          end
        end
      end
      ODC_ST_SAVE_WAIT: begin
        if (nv_done_i) begin
          // Stored copy is now of unknown content
          if (nv_err_i) begin
            ua_lun_set[32'(cdb.lun)] = 1'b1;
          end
          next_state = ODC_ST_IDLE;
        end
      end
      default: next_state = ODC_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state           <= ODC_ST_LOAD;
      cdb             <= '0;
      byte_cnt        <= 4'h0;
      data_cnt        <= 8'h00;
      fail            <= 1'b0;
      pw_ok           <= 1'b0;
      def_o           <= {NUM_LUN{`ODC_LVL_RESET}};
      prior_def       <= {NUM_LUN{`ODC_LVL_RESET}};
      dout_req_o      <= 1'b0;
      status_valid_o  <= 1'b0;
      status_o        <= `ODC_STAT_GOOD;
      cmd_other_o     <= 1'b0;
      cmd_class_o     <= ODC_CL_UNKNOWN;
      cmd_mandatory_o <= 1'b0;
      nv_rd_o         <= 1'b0;
      nv_wr_o         <= 1'b0;
      nv_wdata_o      <= '0;
    end else begin
      state           <= next_state;
      cdb             <= next_cdb;
      byte_cnt        <= next_byte_cnt;
      data_cnt        <= next_data_cnt;
      fail            <= next_fail;
      pw_ok           <= next_pw_ok;
      def_o           <= next_def;
      prior_def       <= next_prior_def;
      dout_req_o      <= next_dout_req;
      status_valid_o  <= next_status_valid;
      status_o        <= next_status;
      cmd_other_o     <= next_cmd_other;
      cmd_class_o     <= next_cmd_class;
      cmd_mandatory_o <= next_cmd_mand;
      nv_rd_o         <= next_nv_rd;
      nv_wr_o         <= next_nv_wr;
      nv_wdata_o      <= next_nv_wdata;
    end
  end

  // ****************************************************************
  // Unit attention per logical unit and initiator
  // ****************************************************************
  logic [NUM_LUN*NUM_INIT-1:0] next_ua;

  for (genvar gl = 0; gl < NUM_LUN; gl++) begin : g_lun
    for (genvar gi = 0; gi < NUM_INIT; gi++) begin : g_init
      logic clr_hit;
      assign clr_hit = ua_clr_i && (32'(ua_clr_lun_i) == gl)
                       && (32'(ua_clr_init_i) == gi);
      // A new attention wins over a clear in the same cycle
      assign next_ua[gl*NUM_INIT+gi] = ua_lun_set[gl]
        || (ua_o[gl*NUM_INIT+gi] && !clr_hit);
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ua_o <= '0;
    end else begin
      ua_o <= next_ua;
    end
  end

  // ****************************************************************
  // Legacy behaviour query
  // ****************************************************************
  odc_query_t next_qry;
  logic [1:0] qry_lvl;
  logic       next_busy;

  always_comb begin
    qry_lvl = 2'h0;
    if (32'(qry_lun_i) < NUM_LUN) begin
      qry_lvl = def_o[32'(qry_lun_i)*2 +: 2];
    end
    next_qry.legacy      = (qry_lvl != `ODC_LVL_CURRENT);
    next_qry.aen_ok      = !next_qry.legacy;
    next_qry.recovery_ok = !next_qry.legacy;
    next_qry.feat_mask   = next_qry.legacy ? 8'h00 : `ODC_FEAT_ALL;
    next_qry.sense_len0  = next_qry.legacy ? `ODC_SENSE0_LEGACY
                                           : `ODC_SENSE0_CURRENT;
    case (qry_lvl)
      `ODC_LVL_LEGACY1: begin
        next_qry.version = `ODC_VER_LVL1;
        next_qry.format  = `ODC_FMT_LVL1;
      end
      `ODC_LVL_LEGACY2: begin
        next_qry.version = `ODC_VER_LVL2;
        next_qry.format  = `ODC_FMT_LVL2;
      end
      default: begin
        next_qry.version = `ODC_VER_LVL3;
        next_qry.format  = `ODC_FMT_LVL3;
      end
    endcase
    next_busy = (next_state != ODC_ST_IDLE);
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      qry_o  <= '0;
      busy_o <= 1'b1;
    end else begin
      qry_o  <= next_qry;
      busy_o <= next_busy;
    end
  end

endmodule : odc_core

// *** dv/odc_nv_model.sv ***
// Non-volatile store answering the block's load and save requests
`timescale 1ns/1ps

module odc_nv_model #(
  parameter int           W    = 16,
  parameter logic [W-1:0] INIT = '1,
  parameter int           LAT  = 3
) (
  input  wire logic         mclk_i,
  input  wire logic         arst_n_i,
  input  wire logic         rd_i,
  input  wire logic         wr_i,
  input  wire logic [W-1:0] wdata_i,
  input  wire logic         err_i,
  output logic [W-1:0]      rdata_o,
  output logic              done_o,
  output logic              err_o,
  output logic [W-1:0]      mem_o
);
  int         cnt;
  logic       wr_pend;
  logic [W-1:0] wbuf;

  initial mem_o = INIT;
  // Read data only valid with done, inverted otherwise
  assign rdata_o = done_o ? mem_o : ~mem_o;
  assign err_o   = done_o & err_i;

  // Store survives reset, unlike the counters
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt     <= 0;
      done_o  <= 1'b0;
      wr_pend <= 1'b0;
    end else begin
      done_o <= (cnt == 1);
      if (rd_i || wr_i)
        cnt <= LAT;
      else if (cnt != 0)
        cnt <= cnt - 1;
      if (wr_i) begin
        wbuf    <= wdata_i;
        wr_pend <= 1'b1;
      end
      if (cnt == 1 && wr_pend) begin
        wr_pend <= 1'b0;
        if (!err_i)
          mem_o <= wbuf;
      end
    end
  end
endmodule : odc_nv_model

// *** dv/odc_core_sva.sv ***
// Port checker of the definition change block
`timescale 1ns/1ps
`include "odc_consts.svh"

module odc_core_sva
  import odc_pkg::*;
#(
  parameter int NUM_LUN  = 8,
  parameter int NUM_INIT = 8
) (
  input wire logic                 mclk_i,
  input wire logic                 arst_n_i,
  input wire logic                 dout_valid_i,
  input wire logic                 abort_i,
  input wire logic                 msg_ack_i,
  input wire logic                 nv_done_i,
  input wire logic                 dout_req_o,
  input wire logic                 status_valid_o,
  input wire logic [7:0]           status_o,
  input wire logic                 cmd_other_o,
  input wire logic                 nv_wr_o,
  input wire logic [NUM_LUN*NUM_INIT-1:0] ua_o,
  input wire logic [NUM_LUN*2-1:0] def_o,
  input wire odc_query_t           qry_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_status_pulse;
    status_valid_o ##1 !status_valid_o;
  endsequence
  // Only a completion or a store answer may change the definition or raise an attention
  sequence s_cause;
    $past(msg_ack_i) || $past(nv_done_i);
  endsequence

  property p_status;
    status_valid_o |-> (status_o == `ODC_STAT_GOOD ||
      status_o == `ODC_STAT_CHECK) ##0 s_status_pulse;
  endproperty
  property p_data_end;
    $fell(dout_req_o) && !$past(abort_i) && !abort_i |->
      $past(dout_valid_i) ##1 status_valid_o;
  endproperty
  property p_def_cause;
    $changed(def_o) |-> s_cause;
  endproperty
  property p_ua_cause;
    (ua_o & ~$past(ua_o)) != '0 |-> s_cause;
  endproperty
  property p_nv_write;
    nv_wr_o |-> $past(msg_ack_i);
  endproperty
  property p_other;
    cmd_other_o |-> !status_valid_o ##1 !cmd_other_o;
  endproperty
  property p_legacy_quiet;
    qry_o.legacy |-> !qry_o.aen_ok && !qry_o.recovery_ok;
  endproperty
  property p_legacy_sense;
    qry_o.legacy |-> qry_o.sense_len0 == 8'h04;
  endproperty
  property p_legacy_ver;
    qry_o.legacy |-> qry_o.version == `ODC_VER_LVL1 &&
      qry_o.format != `ODC_FMT_LVL3 && qry_o.feat_mask == 8'h00;
  endproperty

  a_status: assert property (p_status)
    else $error("status value or pulse width wrong");
  a_data_end: assert property (p_data_end)
    else $error("data phase ended without status");
  a_def_cause: assert property (p_def_cause)
    else $error("definition changed without completion");
  a_ua_cause: assert property (p_ua_cause)
    else $error("attention raised without cause");
  a_nv_write: assert property (p_nv_write)
    else $error("store write without completion");
  a_other: assert property (p_other)
    else $error("other command pulse wrong");
  a_legacy_quiet: assert property (p_legacy_quiet)
    else $error("legacy level allows notices");
  a_legacy_sense: assert property (p_legacy_sense)
    else $error("legacy sense length wrong");
  a_legacy_ver: assert property (p_legacy_ver)
    else $error("legacy inquiry values wrong");
endmodule : odc_core_sva

bind odc_core odc_core_sva #(.NUM_LUN(NUM_LUN), .NUM_INIT(NUM_INIT)) u_sva (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .dout_valid_i(dout_valid_i),
  .abort_i(abort_i), .msg_ack_i(msg_ack_i), .nv_done_i(nv_done_i),
  .dout_req_o(dout_req_o), .status_valid_o(status_valid_o),
  .status_o(status_o), .cmd_other_o(cmd_other_o), .nv_wr_o(nv_wr_o),
  .ua_o(ua_o), .def_o(def_o), .qry_o(qry_o)
);

// *** dv/odc_core_tb.sv ***
// Self-checking bench of the definition change block
`timescale 1ns/1ps
`include "odc_consts.svh"

module odc_core_tb
  import odc_pkg::*;
;
  localparam logic [15:0] KEY = 16'h5A5A;  // Arbitrary value
  localparam logic [15:0] NVI = 16'hFFF9;
  logic mclk_i = 0, arst_n_i = 0, cdb_valid_i = 0, dout_valid_i = 0;
  logic abort_i = 0, msg_ack_i = 0, ua_clr_i = 0, err_inj = 0;
  logic [7:0] cdb_byte_i = 0, dout_byte_i = 0, status_o;
  logic [2:0] ua_clr_lun_i = 0, ua_clr_init_i = 0, qry_lun_i = 0;
  logic [15:0] nv_rdata_i, nv_wdata_o, def_o, nv_mem, exp_def, exp_nv;
  logic nv_done_i, nv_err_i, dout_req_o, status_valid_o, cmd_other_o;
  logic cmd_mandatory_o, nv_rd_o, nv_wr_o, busy_o;
  logic [63:0] ua_o;
  odc_class_t cmd_class_o;
  odc_query_t qry_o;
  int num_errors = 0, cmp_count = 0, seed = 28868;
  byte ops [17] = '{8'h39, 8'h18, 8'h3A, 8'h12, 8'h4C, 8'h4D, 8'h15, 8'h55,
    8'h1A, 8'h5A, 8'h3C, 8'h1C, 8'h03, 8'h1D, 8'h00, 8'h3B, 8'hFF};
  byte cls [17] = '{1, 2, 3, 4, 5, 6, 7, 7, 8, 8, 9, 10, 11, 12, 13, 14, 15};

  odc_core #(.PASS_KEY(KEY)) u_odc_core (.*);
  odc_nv_model #(.INIT(NVI)) u_odc_nv_model (.mclk_i(mclk_i),
    .arst_n_i(arst_n_i), .rd_i(nv_rd_o), .wr_i(nv_wr_o),
    .wdata_i(nv_wdata_o), .err_i(err_inj), .rdata_o(nv_rdata_i),
    .done_o(nv_done_i), .err_o(nv_err_i), .mem_o(nv_mem));

  always #20 mclk_i = ~mclk_i;

  task automatic check(input logic [63:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick

  task automatic wait_idle;
    for (int i = 0; i < 100 && busy_o !== 1'b0; i++) tick(1);
  endtask : wait_idle

  task automatic send_cdb(input logic [7:0] op, input logic [2:0] lun,
      input logic sv, input logic [6:0] dp, input logic [7:0] pl);
    logic [7:0] b [10];
    b = '{op, {lun, 5'h00}, {7'h00, sv}, {1'b0, dp}, 8'h00, 8'h00, 8'h00,
      8'h00, pl, 8'($random(seed))};
    for (int i = 0; i < 10; i++) begin
      tick(1);
      cdb_valid_i = 1'b1;
      cdb_byte_i = b[i];
    end
    tick(1);
    cdb_valid_i = 1'b0;
  endtask : send_cdb

  function automatic logic [20:0] qexp(input logic [1:0] lv);
    logic lg;
    lg = (lv != 2'h3);
    return {lg, lg ? `ODC_VER_LVL1 : `ODC_VER_LVL3, 2'h0, lv - 2'h1,
      lg ? `ODC_SENSE0_LEGACY : `ODC_SENSE0_CURRENT};
  endfunction : qexp

  task automatic run(input int l, input logic sv, input logic [6:0] dp,
      input logic [7:0] pl, input logic [15:0] k, input logic abrt);
    logic ok;
    logic [1:0] old, nl;
    ok = dp <= 7'h03 && (pl == 0 || (pl >= 2 && k === KEY));
    old = exp_def[l*2 +: 2];
    nl = (ok && !abrt && dp != 0) ? dp[1:0] : old;
    qry_lun_i = 3'(l);
    for (int i = 0; i < 8; i++) begin
      ua_clr_i = 1'b1;
      ua_clr_lun_i = 3'(l);
      ua_clr_init_i = 3'(i);
      tick(1);
    end
    ua_clr_i = 1'b0;
    send_cdb(`ODC_OP_CHG_DEF, 3'(l), sv, dp, pl);
    for (int i = 0; i < 30 && pl != 0 && !dout_req_o; i++) tick(1);
    for (int i = 0; i < pl; i++) begin
      dout_valid_i = 1'b1;
      dout_byte_i = i == 0 ? k[15:8] : i == 1 ? k[7:0] : 8'($random(seed));
      tick(1);
    end
    dout_valid_i = 1'b0;
    for (int i = 0; i < 40 && status_valid_o !== 1'b1; i++) tick(1);
    check(status_o, ok ? `ODC_STAT_GOOD : `ODC_STAT_CHECK, "st");
    check(def_o, exp_def, "def early");
    if (ok) begin
      abort_i = abrt;
      msg_ack_i = !abrt;
      tick(1);
      abort_i = 1'b0;
      msg_ack_i = 1'b0;
    end
    wait_idle();
    tick(2);
    exp_def[l*2 +: 2] = nl;
    if (ok && !abrt && sv && !err_inj)
      exp_nv = exp_def;
    check(def_o, exp_def, "def");
    check(nv_mem, exp_nv, "saved");
    check(ua_o[l*8 +: 8], (ok && !abrt && (nl != old || (sv && err_inj))) ?
      8'hFF : 8'h00, "attention");
    check({qry_o.legacy, qry_o.version, qry_o.format, qry_o.sense_len0},
      qexp(nl), "query");
  endtask : run

  // Bound of some twenty thousand cycles, far above the sequence below
  initial begin
    #800000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    tick(4);
    arst_n_i = 1'b1;
    wait_idle();
    tick(1);
    exp_def = NVI;
    exp_nv = NVI;
    check(def_o, NVI, "loaded");
    check(qry_o.sense_len0, 8'h04, "sense0");
    for (int i = 0; i < 17; i++) begin
      send_cdb(ops[i], 3'h0, 1'b0, 7'h00, 8'h00);
      for (int j = 0; j < 40 && cmd_other_o !== 1'b1; j++) tick(1);
      check(cmd_class_o, 5'(cls[i]), "class");
      check(cmd_mandatory_o, ops[i] inside {8'h12, 8'h03, 8'h1D, 8'h00},
        "mandatory");
      wait_idle();
    end
    $display("opcode test done");
    run(0, 1, 7'h03, 8'h00, KEY, 0);
    run(1, 0, 7'h01, 8'h02, KEY, 0);
    run(2, 0, 7'h04, 8'h00, KEY, 0);
    run(2, 0, 7'h40, 8'h00, KEY, 0);
    run(3, 0, 7'h02, 8'h01, KEY, 0);
    run(3, 0, 7'h02, 8'h03, ~KEY, 0);
    run(4, 1, 7'h01, 8'h00, KEY, 1);
    err_inj = 1'b1;
    run(5, 1, 7'h00, 8'h00, KEY, 0);
    err_inj = 1'b0;
    $display("corner test done");
    for (int i = 0; i < 24; i++)
      run($random(seed) & 7, 1'($random(seed)), ($random(seed) & 15) == 0 ?
        7'($random(seed)) : 7'($random(seed) & 3), 8'($random(seed) & 3),
        ($random(seed) & 3) == 0 ? ~KEY : KEY, 0);
    $display("random test done");
    arst_n_i = 1'b0;
    tick(4);
    arst_n_i = 1'b1;
    wait_idle();
    check(def_o, exp_nv, "reloaded");
    $display("reset test done");
    tally_and_finish();
  end
endmodule : odc_core_tb
